/* File: wwdt_pkg.sv */
// Shared constants and types for the windowed watchdog timer
package wwdt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  WWDT_CTRL_IDX    = 8'h3C;
  localparam logic [7:0]  WWDT_SVC_IDX     = 8'h3F;
  localparam logic [7:0]  WWDT_TEST_A_IDX  = 8'h40;
  localparam logic [7:0]  WWDT_TEST_B_IDX  = 8'h41;
  localparam logic [7:0]  WWDT_STATUS_IDX  = 8'h42;
  localparam logic [7:0]  WWDT_MASK_IDX    = 8'h43;
  localparam logic [7:0]  WWDT_CFG_IDX     = 8'h44;
  localparam logic [31:0] WWDT_CTRL_ADDR   = 32'h000000F0;
  localparam logic [31:0] WWDT_SVC_ADDR    = 32'h000000FC;
  localparam logic [31:0] WWDT_TEST_A_ADDR = 32'h00000100;
  localparam logic [31:0] WWDT_TEST_B_ADDR = 32'h00000104;
  localparam logic [31:0] WWDT_STATUS_ADDR = 32'h00000108;
  localparam logic [31:0] WWDT_MASK_ADDR   = 32'h0000010C;
  localparam logic [31:0] WWDT_CFG_ADDR    = 32'h00000110;

  // Control register field positions
  localparam int WWDT_WIN_BIT  = 7;
  localparam int WWDT_HALT_BIT = 6;
  localparam int WWDT_MASK_BIT = 5;
  localparam int WWDT_RATE_MSB = 2;

  // Status bit positions
  localparam int WWDT_EV_TIMEOUT = 0;
  localparam int WWDT_EV_BADVAL  = 1;
  localparam int WWDT_EV_EARLY   = 2;

  // Values after reset
  localparam logic [2:0] WWDT_RATE_RST = 3'h0;
  localparam logic       WWDT_WIN_RST  = 1'b0;
  localparam logic       WWDT_HALT_RST = 1'b0;
  localparam logic [7:0] WWDT_TEST_RST = 8'h00;
  localparam logic [2:0] WWDT_IRQ_RST  = 3'h0;
  localparam logic [23:0] WWDT_CNT_RST = 24'h000000;

  // Service sequence values and the longest rate code
  localparam logic [7:0] WWDT_SVC_FIRST  = 8'h55;
  localparam logic [7:0] WWDT_SVC_SECOND = 8'hAA;
  localparam logic [2:0] WWDT_RATE_MAX   = 3'h7;

  typedef enum logic [1:0] {
    WWDT_SVC_IDLE  = 2'b01,
    WWDT_SVC_ARMED = 2'b10
  } wwdt_svc_t;

  // Last count value of a timeout period for each rate code
  function automatic logic [23:0] wwdt_last(input logic [2:0] rate);
    logic [23:0] v;
    v = 24'h000000;
    case (rate)
      3'h1:    v = 24'h003FFF;
      3'h2:    v = 24'h00FFFF;
      3'h3:    v = 24'h03FFFF;
      3'h4:    v = 24'h0FFFFF;
      3'h5:    v = 24'h3FFFFF;
      3'h6:    v = 24'h7FFFFF;
      3'h7:    v = 24'hFFFFFF;
      default: v = 24'h000000;
    endcase
    return v;
  endfunction

endpackage

/* File: wwdt_edge.sv */
// Two-stage synchroniser and rising-edge detector for a watchdog clock pin
`timescale 1ns/1ps
module wwdt_edge (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  input  wire logic pin_i,
  output logic      tick_o
);
  import wwdt_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } wwdt_edge_t;

  wwdt_edge_t st_q;
  wwdt_edge_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Only the second and third stages feed the edge detector
  assign tick_o = st_q.s2 & ~st_q.s3;
endmodule

/* File: wwdt_count.sv */
// Watchdog period counter with window and expiry detection
`timescale 1ns/1ps
module wwdt_count (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        tick_i,
  input  wire logic        run_i,
  input  wire logic        restart_i,
  input  wire logic [23:0] last_i,
  output logic      [23:0] cnt_o,
  output logic             win_open_o,
  output logic             expire_o
);
  import wwdt_pkg::*;

  typedef struct packed {
    logic [23:0] cnt;
  } wwdt_count_t;

  wwdt_count_t st_q;
  wwdt_count_t st_d;
  logic        at_last;

  assign at_last = (st_q.cnt >= last_i);

  always_comb begin
    st_d = st_q;
    if (restart_i) begin
      st_d.cnt = WWDT_CNT_RST;
    end else if (run_i && tick_i) begin
      st_d.cnt = at_last ? WWDT_CNT_RST : st_q.cnt + 24'h000001;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cnt_o      = st_q.cnt;
  // Final quarter starts at three quarters of the period
  assign win_open_o = (st_q.cnt >= (last_i - (last_i >> 2)));
  // Restart priority is applied by the parent, keeping the expiry free of a loop
  assign expire_o   = run_i && tick_i && at_last;
endmodule

/* File: wwdt_top.sv */
// Windowed watchdog timer with AHB-Lite register slave
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
// Function
// - Window mode: service writes before final quarter of period cause reset.
// - Restart only when second value follows first; repeated first values tolerated.
// - Halt bit set freezes watchdog and real-time interrupt counters in debug.
// - Mask bit set keeps window and rate fields and write-once unused.
// - Nonzero rate write enables counter and starts a new period.
// - Counter reaching timeout before a valid service requests system reset.
// - Debug, halt clear, special mode: longest period, normal servicing.
// - Rate 000 disables; 001..111 give 2^14,16,18,20,22,23,24 cycles.
// - Counter counts watchdog clock, internal RC or oscillator by select bit.
// - Rate 000: service writes ignored; service register reads zero.
// - Enabled: service value other than the two sequence values requests reset.
// - Factory test registers readable always, writable only in special mode.
// - Normal mode: one effective field write; 000 or window 0 still consume it.
module wwdt_top (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        internal_rc_clock_i,
  input  wire logic        oscillator_clock_i,
  input  wire logic        debug_active_i,
  input  wire logic        special_mode_i,
  output logic             sys_reset_req_o,
  output logic             rti_freeze_o,
  output logic             irq_o
);
  import wwdt_pkg::*;

  typedef struct packed {
    logic [2:0]  rate;
    logic        window;
    logic        halt;
    logic        once;
    logic        clk_sel;
    logic [7:0]  test_a;
    logic [7:0]  test_b;
    logic [2:0]  irq_st;
    logic [2:0]  irq_mask;
    wwdt_svc_t   svc;
    logic        rst_req;
    logic        wr_pend;
    logic [7:0]  wr_idx;
    logic [31:0] rdata;
  } wwdt_state_t;

  wwdt_state_t st_q;
  wwdt_state_t st_d;

  logic        rc_tick;
  logic        osc_tick;
  logic        tick;
  logic        enabled;
  logic        freeze;
  logic        override;
  logic [2:0]  eff_rate;
  logic        eff_window;
  logic [23:0] last;
  logic [23:0] cnt;
  logic        win_open;
  logic        expire;
  logic        restart;
  logic        addr_phase;
  logic [7:0]  addr_idx;
  logic [7:0]  wbyte;
  logic        ctrl_wr;
  logic        svc_wr;
  logic [2:0]  events;

  wwdt_edge u_rc_edge (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (internal_rc_clock_i),
    .tick_o    (rc_tick)
  );

  wwdt_edge u_osc_edge (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (oscillator_clock_i),
    .tick_o    (osc_tick)
  );

  assign tick       = st_q.clk_sel ? osc_tick : rc_tick;
  assign enabled    = (st_q.rate != 3'h0);
  assign freeze     = st_q.halt && debug_active_i;
  assign override   = enabled && debug_active_i && !st_q.halt && special_mode_i;
  assign eff_rate   = override ? WWDT_RATE_MAX : st_q.rate;
  assign eff_window = override ? 1'b0 : st_q.window;
  assign last       = wwdt_last(eff_rate);

  assign addr_phase = hsel_i && htrans_i[1] && hready_i;
  assign addr_idx   = haddr_i[9:2];
  assign wbyte      = hwdata_i[7:0];
  assign ctrl_wr    = st_q.wr_pend && (st_q.wr_idx == WWDT_CTRL_IDX);
  assign svc_wr     = st_q.wr_pend && (st_q.wr_idx == WWDT_SVC_IDX);

  wwdt_count u_count (
    .ref_clk_i  (ref_clk_i),
    .rst_b_i    (rst_b_i),
    .tick_i     (tick),
    .run_i      (enabled && !freeze),
    .restart_i  (restart),
    .last_i     (last),
    .cnt_o      (cnt),
    .win_open_o (win_open),
    .expire_o   (expire)
  );

  always_comb begin
    st_d    = st_q;
    restart = 1'b0;
    events  = 3'h0;
    st_d.wr_pend = 1'b0;
    if (addr_phase) begin
      st_d.wr_pend = hwrite_i;
      st_d.wr_idx  = addr_idx;
      case (addr_idx)
        WWDT_CTRL_IDX:   st_d.rdata = {24'h000000, st_q.window, st_q.halt, 3'h0, st_q.rate};
        WWDT_SVC_IDX:    st_d.rdata = 32'h00000000;
        WWDT_TEST_A_IDX: st_d.rdata = {24'h000000, st_q.test_a};
        WWDT_TEST_B_IDX: st_d.rdata = {24'h000000, st_q.test_b};
        WWDT_STATUS_IDX: st_d.rdata = {29'h00000000, st_q.irq_st};
        WWDT_MASK_IDX:   st_d.rdata = {29'h00000000, st_q.irq_mask};
        WWDT_CFG_IDX:    st_d.rdata = {31'h00000000, st_q.clk_sel};
        default:         st_d.rdata = 32'h00000000;
      endcase
    end
    if (ctrl_wr) begin
      if (special_mode_i) begin
        st_d.halt = wbyte[WWDT_HALT_BIT];
        restart   = 1'b1;
        if (!wbyte[WWDT_MASK_BIT]) begin
          st_d.window = wbyte[WWDT_WIN_BIT];
          st_d.rate   = wbyte[WWDT_RATE_MSB:0];
        end
      end else begin
        // Normal mode may only raise the halt bit
        if (wbyte[WWDT_HALT_BIT] && !st_q.halt) begin
          st_d.halt = 1'b1;
          restart   = 1'b1;
        end
        if (!wbyte[WWDT_MASK_BIT] && !st_q.once) begin
          st_d.once = 1'b1;
          if (wbyte[WWDT_WIN_BIT]) begin
            st_d.window = 1'b1;
            restart     = 1'b1;
          end
          if (wbyte[WWDT_RATE_MSB:0] != 3'h0) begin
            st_d.rate = wbyte[WWDT_RATE_MSB:0];
            restart   = 1'b1;
          end
        end
      end
    end
    if (st_q.wr_pend && special_mode_i) begin
      if (st_q.wr_idx == WWDT_TEST_A_IDX) begin
        st_d.test_a = wbyte;
      end
      if (st_q.wr_idx == WWDT_TEST_B_IDX) begin
        st_d.test_b = wbyte;
      end
    end
    if (st_q.wr_pend && (st_q.wr_idx == WWDT_MASK_IDX)) begin
      st_d.irq_mask = hwdata_i[2:0];
    end
    if (st_q.wr_pend && (st_q.wr_idx == WWDT_CFG_IDX)) begin
      st_d.clk_sel = hwdata_i[0];
      // A source change would leave a partial period of the other clock
      restart = restart || (hwdata_i[0] != st_q.clk_sel);
    end
    if (svc_wr && enabled) begin
      if (wbyte != WWDT_SVC_FIRST && wbyte != WWDT_SVC_SECOND) begin
        events[WWDT_EV_BADVAL] = 1'b1;
      end else if (eff_window && !win_open) begin
        events[WWDT_EV_EARLY] = 1'b1;
      end else if (wbyte == WWDT_SVC_FIRST) begin
        st_d.svc = WWDT_SVC_ARMED;
      end else begin
        case (st_q.svc)
          WWDT_SVC_ARMED: begin
            restart  = 1'b1;
            st_d.svc = WWDT_SVC_IDLE;
          end
          WWDT_SVC_IDLE: st_d.svc = WWDT_SVC_IDLE;
          default:       st_d.svc = WWDT_SVC_IDLE;
        endcase
      end
    end
    if (restart && !svc_wr) begin
      st_d.svc = WWDT_SVC_IDLE;
    end
    // Expiry means software missed the period
    // A restart in the same cycle as expiry wins
    events[WWDT_EV_TIMEOUT] = expire && enabled && !restart;
    if (events != 3'h0) begin
      st_d.rst_req = 1'b1;
    end
    // Set wins over a write-one clear in the same cycle
    if (st_q.wr_pend && (st_q.wr_idx == WWDT_STATUS_IDX)) begin
      st_d.irq_st = (st_q.irq_st & ~hwdata_i[2:0]) | events;
    end else begin
      st_d.irq_st = st_q.irq_st | events;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q          <= '0;
      st_q.rate     <= WWDT_RATE_RST;
      st_q.window   <= WWDT_WIN_RST;
      st_q.halt     <= WWDT_HALT_RST;
      st_q.test_a   <= WWDT_TEST_RST;
      st_q.test_b   <= WWDT_TEST_RST;
      st_q.irq_st   <= WWDT_IRQ_RST;
      st_q.irq_mask <= WWDT_IRQ_RST;
      st_q.svc      <= WWDT_SVC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign hrdata_o        = st_q.rdata;
  assign hreadyout_o     = 1'b1;
  assign hresp_o         = 1'b0;
  assign sys_reset_req_o = st_q.rst_req;
  assign rti_freeze_o    = freeze;
  assign irq_o           = |(st_q.irq_st & st_q.irq_mask);

  svc_read_zero_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    addr_phase && !hwrite_i && addr_idx == WWDT_SVC_IDX |=> hrdata_o == 32'h00000000)
    else $error("service register read not zero");

  reset_sticky_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    sys_reset_req_o |=> sys_reset_req_o [*3])
    else $error("reset request dropped");

  expire_reset_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    expire && enabled && !restart |=> sys_reset_req_o && st_q.irq_st[WWDT_EV_TIMEOUT])
    else $error("timeout without reset request");

  bad_value_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    svc_wr && enabled && wbyte != WWDT_SVC_FIRST && wbyte != WWDT_SVC_SECOND |=> sys_reset_req_o)
    else $error("bad service value ignored");

  disabled_ignore_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    svc_wr && !enabled && !sys_reset_req_o && !expire |=> !sys_reset_req_o && $stable(st_q.svc))
    else $error("service write acted while disabled");

  freeze_hold_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    freeze && !restart |=> cnt == $past(cnt))
    else $error("counter moved while halted in debug");

  early_window_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    svc_wr && enabled && eff_window && !win_open |=> sys_reset_req_o)
    else $error("early window service not punished");

  mask_keep_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    ctrl_wr && wbyte[WWDT_MASK_BIT] |=> $stable(st_q.rate) && $stable(st_q.window) && $stable(st_q.once))
    else $error("masked write changed fields");

  once_lock_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    ctrl_wr && st_q.once && !special_mode_i |=> $stable(st_q.rate) && $stable(st_q.window))
    else $error("second normal mode field write took effect");

  test_lock_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    st_q.wr_pend && !special_mode_i |=> $stable(st_q.test_a) && $stable(st_q.test_b))
    else $error("test register written in normal mode");

  rate_start_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    ctrl_wr && !special_mode_i && !st_q.once && !wbyte[WWDT_MASK_BIT] && wbyte[2:0] != 3'h0
    |=> cnt == 24'h000000 && enabled)
    else $error("nonzero rate write did not start period");

  service_restart_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    svc_wr && enabled && wbyte == WWDT_SVC_SECOND && st_q.svc == WWDT_SVC_ARMED && !(eff_window && !win_open)
    |=> cnt == 24'h000000)
    else $error("armed service did not restart period");

  override_rate_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    override |-> last == 24'hFFFFFF && !eff_window)
    else $error("debug override not at longest period");
endmodule

/* File: wwdt_tb.sv */
// Self-checking testbench for the windowed watchdog timer
`timescale 1ns/1ps
module testbench;
  import wwdt_pkg::*;
  logic        ref_clk_i;
  logic        rst_b_i;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        rc_clk;
  logic        rc_run;
  logic        osc_clk;
  logic        debug_act;
  logic        special;
  logic        sys_rst_req;
  logic        rti_freeze;
  logic        irq;
  logic [7:0]  v;
  int          err_count;
  int          n_tests;
  int          cyc;
  int          k;

  wwdt_top wwdt_top_i (
    .ref_clk_i           (ref_clk_i),
    .rst_b_i             (rst_b_i),
    .hsel_i              (hsel),
    .haddr_i             (haddr),
    .htrans_i            (htrans),
    .hwrite_i            (hwrite),
    .hsize_i             (hsize),
    .hwdata_i            (hwdata),
    .hready_i            (hreadyout),
    .hrdata_o            (hrdata),
    .hreadyout_o         (hreadyout),
    .hresp_o             (hresp),
    .internal_rc_clock_i (rc_clk),
    .oscillator_clock_i  (osc_clk),
    .debug_active_i      (debug_act),
    .special_mode_i      (special),
    .sys_reset_req_o     (sys_rst_req),
    .rti_freeze_o        (rti_freeze),
    .irq_o               (irq)
  );

  initial ref_clk_i = 1'b0;
  always #4 ref_clk_i = ~ref_clk_i;

  // One watchdog clock pin toggles at a time: one tick per two reference cycles
  always @(posedge ref_clk_i) begin
    if (rc_run) begin
      rc_clk <= ~rc_clk;
    end else begin
      osc_clk <= ~osc_clk;
    end
  end

  // Hang guard, sized above the longest expected run
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      err_count++;
      finish_test();
    end
  end

  function automatic logic [31:0] ctrl_val(input logic w, input logic h, input logic [2:0] r);
    return {24'h000000, w, h, 3'b000, r};
  endfunction

  function automatic int period_ticks(input logic [2:0] r);
    if (r == 3'h0) begin
      return 0;
    end
    return (r <= 3'h5) ? (1 << (12 + 2 * r)) : (1 << (17 + r));
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Single non-pipelined AHB-Lite transfer; entered just after a rising edge
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    @(posedge ref_clk_i);
    // Only the bench timeout ends a wait for the slave
    while (hreadyout !== 1'b1) begin
      @(posedge ref_clk_i);
    end
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge ref_clk_i);
    while (hreadyout !== 1'b1) begin
      @(posedge ref_clk_i);
    end
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(a, 1'b1, d, dummy);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(a, 1'b0, 32'h00000000, r);
    chk(r, exp);
  endtask

  task automatic do_reset();
    rst_b_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    @(posedge ref_clk_i);
  endtask

  // Waits a bounded number of cycles for the reset request
  task automatic wait_req(input int lim);
    int n;
    n = 0;
    while (sys_rst_req !== 1'b1 && n < lim) begin
      n++;
      @(posedge ref_clk_i);
    end
    chk({31'h0, sys_rst_req}, 32'h1);
  endtask

  task automatic finish_test();
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    rst_b_i = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; rc_clk = 1'b0; rc_run = 1'b1; osc_clk = 1'b0;
    debug_act = 1'b0; special = 1'b0; err_count = 0; n_tests = 0; cyc = 0;
    void'($urandom(89));
    do_reset();
    rd_chk(WWDT_CTRL_ADDR, ctrl_val(WWDT_WIN_RST, WWDT_HALT_RST, WWDT_RATE_RST));
    rd_chk(WWDT_STATUS_ADDR, 32'h00000000);
    rd_chk(32'h00000200, 32'h00000000);
    // Disabled watchdog ignores any service value
    wr(WWDT_SVC_ADDR, {24'h0, 8'h3C});
    repeat (5) @(posedge ref_clk_i);
    chk({31'h0, sys_rst_req}, 32'h0);
    rd_chk(WWDT_SVC_ADDR, 32'h00000000);
    chk({31'h0, hresp}, 32'h0);
    // Test registers: locked in normal mode, open in special mode
    v = 8'($urandom);
    wr(WWDT_TEST_A_ADDR, {24'h0, v});
    rd_chk(WWDT_TEST_A_ADDR, {24'h0, WWDT_TEST_RST});
    special <= 1'b1;
    wr(WWDT_TEST_B_ADDR, {24'h0, v});
    rd_chk(WWDT_TEST_B_ADDR, {24'h0, v});
    special <= 1'b0;
    // Masked write sets halt only and leaves the write-once unused
    wr(WWDT_CTRL_ADDR, 32'h000000E7);
    rd_chk(WWDT_CTRL_ADDR, ctrl_val(1'b0, 1'b1, 3'h0));
    debug_act <= 1'b1;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk({31'h0, rti_freeze}, 32'h1);
    debug_act <= 1'b0;
    wr(WWDT_CTRL_ADDR, ctrl_val(1'b0, 1'b1, 3'h1));
    rd_chk(WWDT_CTRL_ADDR, ctrl_val(1'b0, 1'b1, 3'h1));
    chk({31'h0, rti_freeze}, 32'h0);
    wr(WWDT_CTRL_ADDR, ctrl_val(1'b1, 1'b1, 3'h3));
    rd_chk(WWDT_CTRL_ADDR, ctrl_val(1'b0, 1'b1, 3'h1));
    // Repeated first value then second value restarts the period
    repeat (period_ticks(3'h1)) @(posedge ref_clk_i);
    wr(WWDT_SVC_ADDR, {24'h0, WWDT_SVC_FIRST});
    wr(WWDT_SVC_ADDR, {24'h0, WWDT_SVC_FIRST});
    wr(WWDT_SVC_ADDR, {24'h0, WWDT_SVC_SECOND});
    repeat (2 * period_ticks(3'h1) - 2700) @(posedge ref_clk_i);
    chk({31'h0, sys_rst_req}, 32'h0);
    wait_req(4000);
    rd_chk(WWDT_STATUS_ADDR, 32'h00000001);
    chk({31'h0, irq}, 32'h0);
    wr(WWDT_MASK_ADDR, 32'h00000001);
    // Mask lands at this edge; look once it has settled
    @(negedge ref_clk_i);
    chk({31'h0, irq}, 32'h1);
    wr(WWDT_STATUS_ADDR, 32'h00000001);
    rd_chk(WWDT_STATUS_ADDR, 32'h00000000);
    chk({31'h0, irq}, 32'h0);
    // Stray service values request a reset
    for (k = 0; k < 3; k++) begin
      do_reset();
      v = 8'($urandom);
      if (v == WWDT_SVC_FIRST || v == WWDT_SVC_SECOND) begin
        v = v ^ 8'h01;
      end
      wr(WWDT_CTRL_ADDR, ctrl_val(1'b0, 1'b0, 3'h1));
      wr(WWDT_SVC_ADDR, {24'h0, v});
      wait_req(3);
      rd_chk(WWDT_STATUS_ADDR, 32'h00000002);
    end
    // Debug override in special mode drops the window
    do_reset();
    special <= 1'b1;
    debug_act <= 1'b1;
    wr(WWDT_CTRL_ADDR, ctrl_val(1'b1, 1'b0, 3'h1));
    wr(WWDT_SVC_ADDR, {24'h0, WWDT_SVC_FIRST});
    wr(WWDT_SVC_ADDR, {24'h0, WWDT_SVC_SECOND});
    repeat (5) @(posedge ref_clk_i);
    chk({31'h0, sys_rst_req}, 32'h0);
    special <= 1'b0;
    debug_act <= 1'b0;
    // Window mode on the oscillator pin with the RC pin stopped, then too early
    do_reset();
    rc_run <= 1'b0;
    wr(WWDT_CFG_ADDR, 32'h00000001);
    rd_chk(WWDT_CFG_ADDR, 32'h00000001);
    wr(WWDT_CTRL_ADDR, ctrl_val(1'b1, 1'b0, 3'h1));
    repeat (2 * period_ticks(3'h1) * 13 / 16) @(posedge ref_clk_i);
    wr(WWDT_SVC_ADDR, {24'h0, WWDT_SVC_FIRST});
    wr(WWDT_SVC_ADDR, {24'h0, WWDT_SVC_SECOND});
    repeat (5) @(posedge ref_clk_i);
    chk({31'h0, sys_rst_req}, 32'h0);
    wr(WWDT_SVC_ADDR, {24'h0, WWDT_SVC_FIRST});
    wait_req(3);
    rd_chk(WWDT_STATUS_ADDR, 32'h00000004);
    finish_test();
  end
endmodule
